// *** aaf_adder_datapath.sv ***
// Purpose: add-family, magnitude, pixel and counter-trigger datapath
// Assumes: classic wishbone slave, 32-bit words, one clock, async low reset
// Notes: register RAM held locally (512 words), written by the result path
//
// Notes on behaviour
// - magnitude_op 0110010 writes absolute source, or destination, into destination in 2 clocks.
// - magnitude_op carry takes the original operand's sign bit when carry write requested.
// - immediate source zero-extended from 9 bits unless a prefix is armed, so never negative for magnitude_op without one.
// - unsigned_sum_op 0001000 adds unsigned source and destination into destination.
// - unsigned_sum_op carry is the carry out of bit 31.
// - carry and zero change only under their write effects or a status register write while idle; otherwise held.
// - magnitude, unsigned and signed sums set zero when the written result is zero.
// - signed_sum_op 0001010 adds signed values; 9-bit immediate taken as 0-511.
// - signed_sum_op carry is the sign of the exact sum, bit 32 of the 33-bit signed sum.
// - unsigned_sum_carry_in_op 0001001 adds destination, source and carry; carry out on request.
// - carry-in sums set zero only if zero was set and result is zero.
// - signed_sum_carry_in_op 0001011 adds signed destination, source and carry.
// - signed_sum_carry_in_op carry is set when the signed result is negative.
// - timer_trigger_set_op 1010011 writes sum to destination and selected compare register.
// - compare event fires when the tick counter equals the loaded compare value.
// - pixel_saturating_sum_op 1010010 adds bytes saturating, flags untouched, 7 clocks.
// - immediate bit selects literal source, else source is a register address.
// - a source_extension_prefix extends the next instruction's 9-bit source literal to 32 bits.
// - condition bits 31:28 gate execution; all ones always executes.
`timescale 1ns/100ps
module aaf_adder_datapath
    import aaf_pkg::*;
#(
    parameter int DataW = 32,
    parameter int AddrW = 9
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic [2:0] ctEvent
);
    // =====================================================================
    // storage and state
    logic [DataW-1:0] regRam [2**AddrW];
    aaf_state_t state_q;
    logic [31:0] instr_q;
    logic [22:0] prefix_q;
    logic prefixValid_q;
    logic prefixUse_q;
    logic carry_q;
    logic zero_q;
    logic [31:0] result_q;
    logic [31:0] dstVal_q;
    logic [31:0] srcVal_q;
    logic [2:0] waitCnt_q;
    logic [31:0] tick_q;
    logic [31:0] cmp_q [3];
    logic [2:0] evt_q;
    logic wbAck_q;
    logic [31:0] wbDat_q;
    logic start;
    logic busWrite;
    logic [4:0] busAdr;
    // =====================================================================
    // bus decode
    assign busAdr = {wb_adr_i[4:2], 2'b00};
    assign busWrite = wb_cyc_i && wb_stb_i && wb_we_i && !wbAck_q && (wb_sel_i == 4'hf);
    assign start = busWrite && (busAdr == RegInstr) && (state_q == AAF_IDLE);
    // =====================================================================
    // instruction field views
    logic [6:0] opc;
    logic fxC;
    logic fxZ;
    logic fxI;
    logic [AddrW-1:0] dstAdr;
    logic [8:0] srcFld;
    assign opc = instr_q[OpHi:OpLo];
    assign fxC = instr_q[FxC];
    assign fxZ = instr_q[FxZ];
    assign fxI = instr_q[FxI];
    assign dstAdr = instr_q[DstHi:DstLo];
    assign srcFld = instr_q[SrcHi:SrcLo];
    // =====================================================================
    // combinational execute
    logic [32:0] sumU;
    logic [32:0] sumS;
    logic [31:0] magIn;
    logic [31:0] pixSum;
    logic [31:0] resD;
    logic cD;
    logic zD;
    logic wrC;
    logic wrZ;
    logic magOneOp;
    logic carryIn;
    // one-operand magnitude form encodes the destination in the source field
    assign magOneOp = !fxI && (srcFld == dstAdr);
    assign magIn = magOneOp ? dstVal_q : srcVal_q;
    // only the two carry-in opcodes take the carry; the trigger opcode shares bit 0 but must not
    assign carryIn = carry_q && (opc == OpUnsignedSumCarryIn || opc == OpSignedSumCarryIn);
    assign sumU = {1'b0, dstVal_q} + {1'b0, srcVal_q} + {32'h0000_0000, carryIn};
    assign sumS = {dstVal_q[31], dstVal_q} + {srcVal_q[31], srcVal_q} + {32'h0000_0000, carryIn};
    generate
        for (genvar g = 0; g < 4; g++) begin : gLane
            aaf_lane_sat uLane (
                .a(dstVal_q[8*g+7:8*g]),
                .b(srcVal_q[8*g+7:8*g]),
                .sum(pixSum[8*g+7:8*g])
            );
        end
    endgenerate
    always_comb begin
        resD = sumU[31:0];
        cD = carry_q;
        zD = zero_q;
        wrC = fxC;
        wrZ = fxZ;
        unique case (opc)
            OpMagnitude: begin
                resD = magIn[31] ? (Zero32 - magIn) : magIn;
                cD = magIn[31];
                zD = (resD == Zero32);
            end
            OpUnsignedSum: begin
                resD = sumU[31:0];
                cD = sumU[32];
                zD = (resD == Zero32);
            end
            OpSignedSum: begin
                resD = sumS[31:0];
                cD = sumS[32];
                zD = (resD == Zero32);
            end
            OpUnsignedSumCarryIn: begin
                resD = sumU[31:0];
                cD = sumU[32];
                zD = zero_q && (resD == Zero32);
            end
            OpSignedSumCarryIn: begin
                resD = sumS[31:0];
                cD = sumS[31];
                zD = zero_q && (resD == Zero32);
            end
            OpPixelSum: begin
                resD = pixSum;
                wrC = 1'b0;
                wrZ = 1'b0;
            end
            OpTimerTrigger: begin
                resD = sumU[31:0];
                wrC = 1'b0;
                wrZ = 1'b0;
            end
            default: begin
                wrC = 1'b0;
                wrZ = 1'b0;
            end
        endcase
    end
    // =====================================================================
    // sequencer: fetch operands, execute, commit
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= AAF_IDLE;
            instr_q <= Zero32;
            waitCnt_q <= 3'h0;
            prefixUse_q <= 1'b0;
        end else begin
            unique case (state_q)
                AAF_IDLE: begin
                    if (start) begin
                        instr_q <= wb_dat_i;
                        prefixUse_q <= prefixValid_q;
                        // a false condition simply skips the instruction
                        state_q <= (wb_dat_i[CondHi:CondLo] == CondAlways) ? AAF_FETCH : AAF_IDLE;
                    end
                end
                AAF_FETCH: begin
                    // fetch plus one commit clock gives the two-clock basic op
                    waitCnt_q <= (opc == OpPixelSum) ? 3'(ClocksPixel - 2) : 3'(ClocksBasic - 2);
                    state_q <= AAF_EXEC;
                end
                AAF_EXEC: begin
                    if (waitCnt_q == 3'h0) begin
                        state_q <= AAF_IDLE;
                    end else begin
                        waitCnt_q <= waitCnt_q - 3'h1;
                    end
                end
                default: state_q <= AAF_IDLE;
            endcase
        end
    end
    // operand fetch from the local register RAM
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            dstVal_q <= Zero32;
            srcVal_q <= Zero32;
        end else if (state_q == AAF_FETCH) begin
            dstVal_q <= regRam[dstAdr];
            if (fxI) begin
                srcVal_q <= prefixUse_q ? {prefix_q, srcFld} : {23'h00_0000, srcFld};
            end else begin
                srcVal_q <= regRam[srcFld];
            end
        end
    end
    // register RAM: written on commit only; software sees results through the result register
    always_ff @(posedge clk) begin
        if (state_q == AAF_EXEC && waitCnt_q == 3'h0) begin
            regRam[dstAdr] <= resD;
        end
    end
    // flags and result capture
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            carry_q <= 1'b0;
            zero_q <= 1'b0;
            result_q <= Zero32;
        end else if (state_q == AAF_EXEC && waitCnt_q == 3'h0) begin
            result_q <= resD;
            if (wrC) begin
                carry_q <= cD;
            end
            if (wrZ) begin
                zero_q <= zD;
            end
        end else if (busWrite && busAdr == RegStatus && state_q == AAF_IDLE) begin
            carry_q <= wb_dat_i[StCarry];
            zero_q <= wb_dat_i[StZero];
        end
    end
    // source extension prefix: armed by software, consumed by the next instruction
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prefix_q <= 23'h00_0000;
            prefixValid_q <= 1'b0;
        end else if (busWrite && busAdr == RegPrefix) begin
            prefix_q <= wb_dat_i[AugHi:AugLo];
            prefixValid_q <= 1'b1;
        end else if (start) begin
            prefixValid_q <= 1'b0;
        end
    end
    // =====================================================================
    // tick counter and compare events
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tick_q <= Zero32;
        end else begin
            tick_q <= tick_q + 32'h0000_0001;
        end
    end
    generate
        for (genvar k = 0; k < 3; k++) begin : gCmp
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    cmp_q[k] <= Zero32;
                    evt_q[k] <= 1'b0;
                end else begin
                    if (state_q == AAF_EXEC && waitCnt_q == 3'h0 && opc == OpTimerTrigger
                        && instr_q[FxC:FxZ] == 2'(k)) begin
                        cmp_q[k] <= resD;
                    end
                    evt_q[k] <= (tick_q == cmp_q[k]);
                end
            end
        end
    endgenerate
    assign ctEvent = evt_q;
    // =====================================================================
    // wishbone slave: one wait state, addresses above 0x1c alias onto the eight registers
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wbAck_q <= 1'b0;
            wbDat_q <= Zero32;
        end else begin
            wbAck_q <= wb_cyc_i && wb_stb_i && !wbAck_q;
            unique case (busAdr)
                RegInstr: wbDat_q <= instr_q;
                RegPrefix: wbDat_q <= {prefix_q, 9'h000};
                RegStatus: wbDat_q <= {25'h000_0000, evt_q, prefixValid_q, zero_q, carry_q, state_q != AAF_IDLE};
                RegResult: wbDat_q <= result_q;
                RegTick: wbDat_q <= tick_q;
                RegCmpFirst: wbDat_q <= cmp_q[TrigFirst];
                RegCmpSecond: wbDat_q <= cmp_q[TrigSecond];
                RegCmpThird: wbDat_q <= cmp_q[TrigThird];
                default: wbDat_q <= Zero32;
            endcase
        end
    end
    assign wb_ack_o = wbAck_q;
    assign wb_dat_o = wbDat_q;
endmodule : aaf_adder_datapath

// *** aaf_pkg.sv ***
// Purpose: shared constants for the add-family and magnitude datapath
// Assumes: 32-bit data, 9-bit register addresses
// Notes: offsets are word-aligned byte addresses on the register bus
package aaf_pkg;
    // =====================================================================
    // instruction word fields
    localparam int CondHi = 31;
    localparam int CondLo = 28;
    localparam int OpHi = 27;
    localparam int OpLo = 21;
    localparam int FxC = 20;
    localparam int FxZ = 19;
    localparam int FxI = 18;
    localparam int DstHi = 17;
    localparam int DstLo = 9;
    localparam int SrcHi = 8;
    localparam int SrcLo = 0;
    localparam int AugHi = 31;
    localparam int AugLo = 9;
    localparam logic [3:0] CondAlways = 4'hf;
    localparam logic [6:0] OpMagnitude = 7'h32;
    localparam logic [6:0] OpUnsignedSum = 7'h08;
    localparam logic [6:0] OpUnsignedSumCarryIn = 7'h09;
    localparam logic [6:0] OpSignedSum = 7'h0a;
    localparam logic [6:0] OpSignedSumCarryIn = 7'h0b;
    localparam logic [6:0] OpPixelSum = 7'h52;
    localparam logic [6:0] OpTimerTrigger = 7'h53;
    localparam logic [1:0] TrigFirst = 2'h0;
    localparam logic [1:0] TrigSecond = 2'h1;
    localparam logic [1:0] TrigThird = 2'h2;
    // =====================================================================
    // timing, in clocks
    localparam int ClocksBasic = 2;
    localparam int ClocksPixel = 7;
    // =====================================================================
    // register map (byte addresses, word index = bits 4:2)
    localparam logic [4:0] RegInstr = 5'h00;
    localparam logic [4:0] RegPrefix = 5'h04;
    localparam logic [4:0] RegStatus = 5'h08;
    localparam logic [4:0] RegResult = 5'h0c;
    localparam logic [4:0] RegTick = 5'h10;
    localparam logic [4:0] RegCmpFirst = 5'h14;
    localparam logic [4:0] RegCmpSecond = 5'h18;
    localparam logic [4:0] RegCmpThird = 5'h1c;
    // status bits
    localparam int StBusy = 0;
    localparam int StCarry = 1;
    localparam int StZero = 2;
    localparam int StPrefix = 3;
    localparam int StEvtLo = 4;
    localparam logic [31:0] Zero32 = 32'h0000_0000;
    // =====================================================================
    typedef enum logic [1:0] {AAF_IDLE, AAF_FETCH, AAF_EXEC, AAF_WB} aaf_state_t;
endpackage : aaf_pkg

// *** aaf_lane_sat.sv ***
// Purpose: one saturating byte lane adder for the pixel sum
// Assumes: unsigned 8-bit colour channels
// Notes: purely combinational
`timescale 1ns/100ps
module aaf_lane_sat (
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    output logic [7:0] sum
);
    logic [8:0] wide;
    // no carry leaves the lane, so lanes stay independent
    assign wide = {1'b0, a} + {1'b0, b};
    assign sum = wide[8] ? 8'hff : wide[7:0];
endmodule : aaf_lane_sat

// *** aaf_adder_datapath_properties.sv ***
// Purpose: bus and timing properties of the adder datapath
// Assumes: registered ack one cycle after take
// Notes: busy is tracked from launches seen on the bus
`timescale 1ns/100ps
module aaf_adder_datapath_properties
    import aaf_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [2:0] ctEvent
);
    // ==========================================================
    // launch tracker; skipped conditions count too, busy either way is short
    logic [3:0] cnt_q;
    logic [3:0] lat_q;
    logic take;
    logic launch;
    logic stRead;
    assign take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign launch = take & wb_we_i & (wb_adr_i[4:2] == 3'h0) & (wb_sel_i == 4'hf) & (cnt_q > lat_q);
    assign stRead = take & ~wb_we_i & (wb_adr_i[4:2] == RegStatus[4:2]);
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 4'hf;
            lat_q <= 4'h2;
        end else if (launch) begin
            cnt_q <= 4'h1;
            lat_q <= (wb_dat_i[OpHi:OpLo] == OpPixelSum) ? 4'h7 : 4'h2;
        end else if (cnt_q != 4'hf) begin
            cnt_q <= cnt_q + 4'h1;
        end
    end
    // ==========================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    chk_ack_after_take: assert property (take |=> wb_ack_o) else $error("no ack after take");
    chk_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    chk_ack_has_request: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i & wb_stb_i)) else $error("stray ack");
    chk_idle_no_ack: assert property (!(wb_cyc_i & wb_stb_i) && !wb_ack_o |=> !wb_ack_o) else $error("ack idle");
    chk_pixel_busy_held: assert property (stRead && lat_q == 4'h7 && cnt_q inside {[4'h3:4'h5]}
        |=> wb_dat_o[StBusy]) else $error("pixel op not busy");
    chk_op_done_idle: assert property (stRead && cnt_q >= lat_q + 4'h2 |=> !wb_dat_o[StBusy])
        else $error("op still busy");
    chk_event_single: assert property (|ctEvent |=> (ctEvent & $past(ctEvent)) == 3'h0)
        else $error("event longer than one cycle");
    chk_event_quiet_gap: assert property ($rose(ctEvent[1]) |=> !ctEvent[1] [*4])
        else $error("event repeats");
    cover property (stRead && lat_q == 4'h7 && cnt_q == 4'h3);
    cover property (|ctEvent);
    cover property (take && wb_we_i && wb_sel_i != 4'hf);
endmodule : aaf_adder_datapath_properties

bind aaf_adder_datapath aaf_adder_datapath_properties chk_u (.clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ctEvent(ctEvent));

// *** aaf_wb_host.sv ***
// Purpose: wishbone master standing in for the core pipeline
// Assumes: slave answers every held request
// Notes: at least two idle cycles follow every transfer
`timescale 1ns/100ps
module aaf_wb_host (
    input wire logic clk,
    input wire logic [31:0] datI,
    input wire logic ack,
    output logic cyc,
    output logic stb,
    output logic we,
    output logic [31:0] adr,
    output logic [31:0] datO,
    output logic [3:0] sel
);
    // ==========================================================
    // request held until ack is sampled, released at that edge
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [31:0] r);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        datO <= d;
        sel <= s;
        do @(posedge clk); while (ack !== 1'b1);
        r = datI;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        @(posedge clk);
    endtask : xfer
    initial begin
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 32'h0000_0000;
        datO = 32'h0000_0000;
        sel = 4'hf;
    end
endmodule : aaf_wb_host

// *** aaf_adder_datapath_bench.sv ***
// Purpose: self-checking bench for the adder datapath
// Assumes: registers 0-3 seeded by the bench before use
// Notes: a local copy of those registers predicts every result
`timescale 1ns/100ps
module aaf_adder_datapath_bench
    import aaf_pkg::*;
;
    typedef struct {logic [31:0] exp; logic [31:0] msk;} aaf_note_t;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic cyc, stb, we, ack, cf = 1'b0, zf = 1'b0;
    logic [31:0] adr, datW, datR, lfsr = 32'h0000_0029;
    logic [31:0] lastRes = 32'h0000_0000;
    logic [3:0] sel;
    logic [2:0] ctEvent;
    logic [31:0] mreg [4];
    logic [31:0] cmp [3];
    aaf_note_t notes [$];
    int err_count = 0;
    int compares = 0;
    always #25 clk = ~clk;
    aaf_adder_datapath dut_u (.clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_dat_i(datW), .wb_sel_i(sel), .wb_dat_o(datR), .wb_ack_o(ack), .ctEvent(ctEvent));
    aaf_wb_host host_u (.clk(clk), .datI(datR), .ack(ack), .cyc(cyc), .stb(stb), .we(we), .adr(adr),
        .datO(datW), .sel(sel));
    // ==========================================================
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction : rnd
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic finish_test();
        $display("compares %0d errors %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : finish_test
    // monitor: oldest note belongs to the read being acked
    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0 && notes.size() > 0) begin
            if (notes[0].msk != 32'h0000_0000) check(datR & notes[0].msk, notes[0].exp);
            void'(notes.pop_front());
        end
    end
    task automatic rd(input logic [4:0] a, input logic [31:0] e, input logic [31:0] m, output logic [31:0] r);
        notes.push_back('{e, m});
        host_u.xfer(1'b0, {27'h0, a}, 32'h0000_0000, 4'hf, r);
    endtask : rd
    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        host_u.xfer(1'b1, {27'h0, a}, d, s, r);
    endtask : wr
    task automatic run(input logic [3:0] cond, input logic [6:0] op, input logic [2:0] fx, input logic [1:0] dst,
                       input logic [8:0] src, input logic pre, input logic [31:0] lit);
        logic [31:0] s;
        logic [31:0] d;
        logic [32:0] w;
        logic [8:0] t;
        logic [31:0] r;
        s = fx[0] ? (pre ? {lit[31:9], src} : {23'h0, src}) : mreg[src[1:0]];
        d = mreg[dst];
        w = {1'b0, d} + {1'b0, s} + ((op == OpUnsignedSumCarryIn) ? cf : 1'b0);
        if (op == OpMagnitude) w = {s[31], s[31] ? -s : s};
        if (op == OpSignedSum) w = {d[31], d} + {s[31], s};
        if (op == OpSignedSumCarryIn) w = {d[31], d} + {s[31], s} + cf;
        if (op == OpSignedSumCarryIn) w[32] = w[31];
        for (int k = 0; k < 4; k++) begin
            t = d[8*k+:8] + s[8*k+:8];
            if (op == OpPixelSum) w[8*k+:8] = t[8] ? 8'hff : t[7:0];
        end
        if (pre) wr(RegPrefix, lit, 4'hf);
        wr(RegInstr, {cond, op, fx, 7'h0, dst, src}, 4'hf);
        r = 32'h0000_0001;
        while (r[StBusy] !== 1'b0) rd(RegStatus, 32'h0000_0000, 32'h0000_0000, r);
        if (cond == CondAlways) begin
            mreg[dst] = w[31:0];
            lastRes = w[31:0];
            if (op == OpTimerTrigger) cmp[fx[2:1]] = w[31:0];
            // or-ing bit 1 folds both carry-in opcodes, 0001001 and 0001011, onto one value
            if (op != OpPixelSum && op != OpTimerTrigger && fx[1])
                zf = (w[31:0] == Zero32) && (zf || (op | 7'h02) != OpSignedSumCarryIn);
            if (op != OpPixelSum && op != OpTimerTrigger && fx[2]) cf = w[32];
        end
        rd(RegResult, lastRes, 32'hffff_ffff, r);
        rd(RegStatus, {28'h0, 1'b0, zf, cf, 1'b0}, 32'h0000_000f, r);
    endtask : run
    // ==========================================================
    initial begin
        logic [31:0] r;
        logic [6:0] ops [6];
        logic [2:0] fx;
        int n;
        ops = '{OpMagnitude, OpUnsignedSum, OpUnsignedSumCarryIn, OpSignedSum, OpSignedSumCarryIn, OpPixelSum};
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            run(CondAlways, OpMagnitude, 3'b001, k[1:0], 9'h000, 1'b0, 32'h0000_0000);
            r = rnd();
            run(CondAlways, OpUnsignedSum, 3'b001, k[1:0], r[8:0], 1'b1, r);
        end
        for (int i = 0; i < 60; i++) begin
            r = rnd();
            fx = (ops[i % 6] == OpPixelSum) ? {2'b00, r[31]} : r[31:29];
            run(CondAlways, ops[i % 6], fx, r[1:0], fx[0] ? r[10:2] : {7'h0, r[3:2]}, r[12] & fx[0], rnd());
        end
        run(4'h0, OpUnsignedSum, 3'b111, 2'h0, 9'h1ff, 1'b0, 32'h0000_0000);
        for (int k = 0; k < 3; k++) begin
            rd(RegTick, 32'h0000_0000, 32'h0000_0000, r);
            r = r + 32'h0000_012c - mreg[k];
            run(CondAlways, OpTimerTrigger, {k[1:0], 1'b1}, k[1:0], r[8:0], 1'b1, r);
            rd(RegCmpFirst + {k[2:0], 2'b00}, cmp[k], 32'hffff_ffff, r);
            n = 0;
            while (ctEvent[k] !== 1'b1 && n < 400) begin
                @(posedge clk);
                n++;
            end
            check({31'h0, n > 150 && n < 300}, 32'h0000_0001);
        end
        wr(RegInstr, {CondAlways, OpPixelSum, 21'h0}, 4'h3);
        rd(RegStatus, 32'h0000_0000, 32'h0000_0001, r);
        finish_test();
    end
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        finish_test();
    end
endmodule : aaf_adder_datapath_bench
